/* File: imsc_pkg.sv */
// Shared constants for the mask-level stack and factor mode controller.
// Assumes one 50 MHz clock and a word-wide register path between the ends.
package imsc_pkg;
  // ==========================================================
  // Device register map
  localparam logic [31:0] FACTOR_MODE_CTL_0_ADDR = 32'hffffe000;
  localparam logic [31:0] MASK_LEVEL_STACK_ADDR = 32'hffffe10c;
  localparam logic [31:0] FACTOR_MODE_CTL_0_RST = 32'h00000000;
  localparam logic [31:0] MASK_LEVEL_STACK_RST = 32'h00000000;
  // ==========================================================
  // Field layout
  localparam int NUM_FACTORS = 4;
  localparam int LEVEL_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int SLOT_STRIDE = 4;
  localparam int LEVEL_CMD_BIT = 31;
  localparam int BYTE_W = 8;
  localparam int SEL_LSB = 5;
  localparam int XFER_FLAG_BIT = 4;
  localparam int PRIO_LSB = 0;
  localparam logic [7:0] MODE_BYTE_MASK = 8'h77;
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  // Active-state select codes
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_FALL = 2'h2;
  localparam logic [1:0] SEL_RISE = 2'h3;
  // ==========================================================
  // Core-end APB registers
  localparam logic [7:0] CORE_CMD_OFS = 8'h00;
  localparam logic [7:0] CORE_ADDR_OFS = 8'h04;
  localparam logic [7:0] CORE_WDATA_OFS = 8'h08;
  localparam logic [7:0] CORE_RDATA_OFS = 8'h0c;
  localparam logic [7:0] CORE_STATUS_OFS = 8'h10;
  localparam logic [7:0] CORE_IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] CORE_IRQ_MASK_OFS = 8'h18;
  localparam logic [7:0] CORE_ACCEPT_OFS = 8'h1c;
  localparam int EV_DONE = 0;
  localparam int EV_PEND = 1;
  localparam int EV_TAKEN = 2;
  localparam int NUM_EV = 3;
  // ==========================================================
  // Core-end access state
  typedef enum logic [0:0] {
    IMSC_IDLE = 1'b0,
    IMSC_BUSY = 1'b1
  } imsc_state_e;
endpackage

/* File: imsc_link_if.sv */
// Carrier between the interrupt controller and the processor-core end.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/1ps
interface imsc_link_if;
  // ==========================================================
  // Register path and interrupt notification
  logic reg_req;
  logic reg_we;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_ack;
  logic irq_pend;
  logic [2:0] irq_level;
  logic [1:0] irq_factor;
  logic irq_accept;
  modport dev (
    input reg_req, reg_we, reg_addr, reg_wdata, irq_accept,
    output reg_rdata, reg_ack, irq_pend, irq_level, irq_factor
  );
  modport core (
    output reg_req, reg_we, reg_addr, reg_wdata, irq_accept,
    input reg_rdata, reg_ack, irq_pend, irq_level, irq_factor
  );
endinterface

/* File: imsc_req_detect.sv */
// One request input decoded by its active-state select.
// Assumes sel_in comes from a register on the same clock.
`timescale 1ns/1ps
module imsc_req_detect #(
  parameter bit SYNC_EN = 1'b1
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic raw_in,
  input wire logic [1:0] sel_in,
  output logic level_out,
  output logic edge_out,
  output logic onset_out
);
  // ==========================================================
  // Two-stage synchroniser for pins, bypass for on-chip sources
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic samp;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      prev_reg <= samp;
    end
  end
  assign samp = SYNC_EN ? sync_reg : raw_in;
  // Decode: low/high level, falling/rising edge
  wire is_low = (sel_in == imsc_pkg::SEL_LOW);
  wire is_high = (sel_in == imsc_pkg::SEL_HIGH);
  wire act_now = is_low ? !samp : samp;
  wire act_prev = is_low ? !prev_reg : prev_reg;
  wire fell = prev_reg && !samp;
  wire rose = !prev_reg && samp;
  assign level_out = (is_low || is_high) && act_now;
  assign edge_out = (sel_in == imsc_pkg::SEL_FALL) ? fell : ((sel_in == imsc_pkg::SEL_RISE) && rose);
  // Onset covers a level that just became active as well as an edge
  assign onset_out = edge_out || ((is_low || is_high) && act_now && !act_prev);
endmodule

/* File: imsc_ctl_dev.sv */
// Interrupt controller end: mask-level stack and first factor mode word.
// Assumes the core end drives the link and only makes 32-bit accesses.
// Contract
// - Software uses only full 32-bit stack accesses.
// - Current level bits 2:0, seven saved nibbles, zeros.
// - Accepted interrupt pushes its level onto stack.
// - Bit 31 write-only: 0 pops, 1 overwrites.
// - Overwrite loads bits 2:0, saved slots untouched.
// - Pop shifts slots down, slot 7 cleared.
// - Handler pops before exception return.
// - Each factor holds level, active state, transfer flag.
// - Factor n in byte n, fixed field layout.
// - Factor 0 software source, only select 00 works.
// - Select 00 low, 01 high, 10 fall, 11 rise.
// - Flag 0 interrupts core, flag 1 triggers transfer.
// - Level 000 suppresses, 001-111 give priorities 1-7.
// - Flag set: field is transfer channel 0-7.
// - Mode word resets to zero, all disabled.
// - Highest level presented, lower ones stay pending.
// - Equal levels: lower factor number reported.
`timescale 1ns/1ps
module imsc_ctl_dev #(
  parameter int NUM_FACTORS = imsc_pkg::NUM_FACTORS
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  imsc_link_if.dev link,
  input wire logic sw_req_n_in,
  input wire logic [2:0] req_pin_in,
  output logic dma_trig_out,
  output logic [2:0] dma_chan_out
);
  localparam int LW = imsc_pkg::LEVEL_W;
  localparam int BW = imsc_pkg::BYTE_W;

  // ==========================================================
  // Elaboration check
  if (NUM_FACTORS != imsc_pkg::NUM_FACTORS) begin : g_bad_factors
    $error("imsc_ctl_dev serves exactly four factors");
  end

  // ==========================================================
  // Register access decode
  wire take = link.reg_req && !link.reg_ack;
  wire hit_mode = (link.reg_addr == imsc_pkg::FACTOR_MODE_CTL_0_ADDR);
  wire hit_stack = (link.reg_addr == imsc_pkg::MASK_LEVEL_STACK_ADDR);
  wire wr_mode = take && link.reg_we && hit_mode;
  wire wr_stack = take && link.reg_we && hit_stack;
  wire cmd_set = link.reg_wdata[imsc_pkg::LEVEL_CMD_BIT];

  // ==========================================================
  // Mode word: only the documented field bits are stored
  logic [31:0] mode_reg;
  wire [31:0] mode_mask = {NUM_FACTORS{imsc_pkg::MODE_BYTE_MASK}};
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_reg <= imsc_pkg::FACTOR_MODE_CTL_0_RST;
    end else if (wr_mode) begin
      mode_reg <= link.reg_wdata & mode_mask;
    end
  end

  // Per-factor field views
  logic [1:0] sel [NUM_FACTORS];
  logic xfer_flag [NUM_FACTORS];
  logic [LW-1:0] prio [NUM_FACTORS];
  logic [NUM_FACTORS-1:0] lvl_act;
  logic [NUM_FACTORS-1:0] edge_evt;
  logic [NUM_FACTORS-1:0] onset;
  logic [NUM_FACTORS-1:0] is_level;
  logic [NUM_FACTORS-1:0] pend_reg;
  logic [NUM_FACTORS-1:0] want;
  logic [NUM_FACTORS-1:0] clr_pend;
  wire [NUM_FACTORS-1:0] raw_req = {req_pin_in, sw_req_n_in};

  // ==========================================================
  // Per-factor detection and interrupt request
  for (genvar i = 0; i < NUM_FACTORS; i++) begin : g_factor
    assign sel[i] = mode_reg[i*BW+imsc_pkg::SEL_LSB +: 2];
    assign xfer_flag[i] = mode_reg[i*BW+imsc_pkg::XFER_FLAG_BIT];
    assign prio[i] = mode_reg[i*BW+imsc_pkg::PRIO_LSB +: LW];
    // Factor 0 is driven by on-chip logic, so it skips the synchroniser
    imsc_req_detect #(
      .SYNC_EN(i != 0)
    ) u_det (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .raw_in(raw_req[i]),
      .sel_in(sel[i]),
      .level_out(lvl_act[i]),
      .edge_out(edge_evt[i]),
      .onset_out(onset[i])
    );
    assign is_level[i] = !sel[i][1];
    // Edge requests latch until accepted; a new edge beats the clear
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        pend_reg[i] <= 1'b0;
      end else if (edge_evt[i] && !xfer_flag[i]) begin
        pend_reg[i] <= 1'b1;
      end else if (clr_pend[i] || is_level[i]) begin
        pend_reg[i] <= 1'b0;
      end
    end
    if (i == 0) begin : g_sw
      // Software source works only with low-level select
      assign want[i] = (sel[i] == imsc_pkg::SEL_LOW) && lvl_act[i] && !xfer_flag[i]
                       && (prio[i] != imsc_pkg::LEVEL_NONE);
    end else begin : g_pin
      assign want[i] = (is_level[i] ? lvl_act[i] : pend_reg[i]) && !xfer_flag[i]
                       && (prio[i] != imsc_pkg::LEVEL_NONE);
    end
  end

  // ==========================================================
  // Priority arbitration: strict greater keeps the lower number on ties
  logic [LW-1:0] best_lvl;
  logic [1:0] best_idx;
  always_comb begin
    best_lvl = imsc_pkg::LEVEL_NONE;
    best_idx = 2'h0;
    for (int k = 0; k < NUM_FACTORS; k++) begin
      if (want[k] && (prio[k] > best_lvl)) begin
        best_lvl = prio[k];
        best_idx = 2'(k);
      end
    end
  end

  // ==========================================================
  // Transfer-engine trigger: lowest flagged factor with an onset
  logic dma_hit;
  logic [2:0] dma_sel;
  always_comb begin
    dma_hit = 1'b0;
    dma_sel = 3'h0;
    for (int k = NUM_FACTORS - 1; k >= 0; k--) begin
      if (xfer_flag[k] && onset[k] && (k != 0 || sel[0] == imsc_pkg::SEL_LOW)) begin
        dma_hit = 1'b1;
        dma_sel = prio[k];
      end
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dma_trig_out <= 1'b0;
      dma_chan_out <= 3'h0;
    end else begin
      dma_trig_out <= dma_hit;
      if (dma_hit) begin
        dma_chan_out <= dma_sel;
      end
    end
  end

  // ==========================================================
  // Mask-level stack: slot 0 is the current level
  logic [LW-1:0] stk_reg [imsc_pkg::STACK_DEPTH];
  logic [LW-1:0] stk_next [imsc_pkg::STACK_DEPTH];
  // Only an interrupt above the current mask is signalled
  wire above = (best_lvl > stk_reg[0]);
  wire push = link.irq_accept && above;
  assign clr_pend = push ? (4'h1 << best_idx) : 4'h0;

  // Push has priority over a same-cycle stack write, which is then lost
  always_comb begin
    for (int k = 0; k < imsc_pkg::STACK_DEPTH; k++) begin
      stk_next[k] = stk_reg[k];
    end
    if (push) begin
      stk_next[0] = best_lvl;
      for (int k = 1; k < imsc_pkg::STACK_DEPTH; k++) begin
        stk_next[k] = stk_reg[k-1];
      end
    end else if (wr_stack && cmd_set) begin
      stk_next[0] = link.reg_wdata[LW-1:0];
    end else if (wr_stack) begin
      for (int k = 0; k < imsc_pkg::STACK_DEPTH - 1; k++) begin
        stk_next[k] = stk_reg[k+1];
      end
      stk_next[imsc_pkg::STACK_DEPTH-1] = imsc_pkg::LEVEL_NONE;
    end
  end

  for (genvar s = 0; s < imsc_pkg::STACK_DEPTH; s++) begin : g_slot
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        stk_reg[s] <= imsc_pkg::LEVEL_NONE;
      end else begin
        stk_reg[s] <= stk_next[s];
      end
    end
  end

  // Read image: command bit and gaps read zero
  logic [31:0] stack_img;
  always_comb begin
    stack_img = imsc_pkg::MASK_LEVEL_STACK_RST;
    for (int k = 0; k < imsc_pkg::STACK_DEPTH; k++) begin
      stack_img[k*imsc_pkg::SLOT_STRIDE +: LW] = stk_reg[k];
    end
  end
  wire [31:0] rd_mux = hit_mode ? mode_reg : (hit_stack ? stack_img : 32'h00000000);

  // ==========================================================
  // Link answers: one cycle after the request is taken
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.reg_ack <= 1'b0;
      link.reg_rdata <= 32'h00000000;
    end else begin
      link.reg_ack <= take;
      if (take && !link.reg_we) begin
        link.reg_rdata <= rd_mux;
      end
    end
  end

  // Notification to the core
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.irq_level <= 3'h0;
      link.irq_factor <= 2'h0;
    end else begin
      link.irq_level <= above ? best_lvl : imsc_pkg::LEVEL_NONE;
      link.irq_factor <= best_idx;
    end
  end
  // Pending flag is combinational so an accept never sees a stale request
  assign link.irq_pend = above;
endmodule

/* File: imsc_core_end.sv */
// Processor-core end: APB-controlled register master and interrupt taker.
// Assumes the controller answers each link request with one ack pulse.
`timescale 1ns/1ps
module imsc_core_end (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  imsc_link_if.core link,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic irq_out
);
  // ==========================================================
  // APB decode: zero-wait slave
  wire apb_wr = psel_in && penable_in && pwrite_in;
  wire wr_cmd = apb_wr && (paddr_in == imsc_pkg::CORE_CMD_OFS);
  wire wr_addr = apb_wr && (paddr_in == imsc_pkg::CORE_ADDR_OFS);
  wire wr_wdata = apb_wr && (paddr_in == imsc_pkg::CORE_WDATA_OFS);
  wire wr_stat = apb_wr && (paddr_in == imsc_pkg::CORE_IRQ_STAT_OFS);
  wire wr_mask = apb_wr && (paddr_in == imsc_pkg::CORE_IRQ_MASK_OFS);
  wire wr_acc = apb_wr && (paddr_in == imsc_pkg::CORE_ACCEPT_OFS);
  assign pready_out = 1'b1;

  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic [imsc_pkg::NUM_EV-1:0] stat_reg;
  logic [imsc_pkg::NUM_EV-1:0] mask_reg;
  logic [2:0] taken_lvl_reg;
  logic [1:0] taken_fac_reg;
  logic acc_reg;
  imsc_pkg::imsc_state_e state_reg;
  imsc_pkg::imsc_state_e state_next;

  // ==========================================================
  // Link request: always a full word; commands ignored while busy
  wire start = wr_cmd && (state_reg == imsc_pkg::IMSC_IDLE);
  wire done = (state_reg == imsc_pkg::IMSC_BUSY) && link.reg_ack;
  always_comb begin
    case (state_reg)
      imsc_pkg::IMSC_IDLE: state_next = start ? imsc_pkg::IMSC_BUSY : imsc_pkg::IMSC_IDLE;
      imsc_pkg::IMSC_BUSY: state_next = done ? imsc_pkg::IMSC_IDLE : imsc_pkg::IMSC_BUSY;
      default: state_next = imsc_pkg::IMSC_IDLE;
    endcase
  end
  assign link.reg_req = (state_reg == imsc_pkg::IMSC_BUSY);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= imsc_pkg::IMSC_IDLE;
      link.reg_we <= 1'b0;
      link.reg_addr <= 32'h00000000;
      link.reg_wdata <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      if (start) begin
        link.reg_we <= pwdata_in[0];
        link.reg_addr <= addr_reg;
        link.reg_wdata <= wdata_reg;
      end
    end
  end

  // Software-held address, data and captured read data
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      mask_reg <= '0;
    end else begin
      if (wr_addr) addr_reg <= pwdata_in;
      if (wr_wdata) wdata_reg <= pwdata_in;
      if (wr_mask) mask_reg <= pwdata_in[imsc_pkg::NUM_EV-1:0];
      if (done && !link.reg_we) rdata_reg <= link.reg_rdata;
    end
  end

  // ==========================================================
  // Interrupt acceptance: one pulse per software accept, only if pending
  wire accept_now = wr_acc && pwdata_in[0] && link.irq_pend;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_reg <= 1'b0;
      taken_lvl_reg <= 3'h0;
      taken_fac_reg <= 2'h0;
    end else begin
      acc_reg <= 1'b0;
      if (accept_now) begin
        acc_reg <= 1'b1;
        taken_lvl_reg <= link.irq_level;
        taken_fac_reg <= link.irq_factor;
      end
    end
  end
  // Accept is driven combinationally so it pairs with the level it saw
  assign link.irq_accept = accept_now;

  // ==========================================================
  // Sticky events, write one to clear; a new event wins over the clear
  wire [imsc_pkg::NUM_EV-1:0] ev = {acc_reg, link.irq_pend, done};
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= ev | (stat_reg & ~(wr_stat ? pwdata_in[imsc_pkg::NUM_EV-1:0] : '0));
    end
  end
  assign irq_out = |(stat_reg & mask_reg);

  // Read mux
  wire [31:0] status_img = {24'h000000, taken_fac_reg, taken_lvl_reg,
                            link.irq_pend, 1'b0, state_reg == imsc_pkg::IMSC_BUSY};
  always_comb begin
    case (paddr_in)
      imsc_pkg::CORE_ADDR_OFS: prdata_out = addr_reg;
      imsc_pkg::CORE_WDATA_OFS: prdata_out = wdata_reg;
      imsc_pkg::CORE_RDATA_OFS: prdata_out = rdata_reg;
      imsc_pkg::CORE_STATUS_OFS: prdata_out = status_img;
      imsc_pkg::CORE_IRQ_STAT_OFS: prdata_out = {29'h0, stat_reg};
      imsc_pkg::CORE_IRQ_MASK_OFS: prdata_out = {29'h0, mask_reg};
      default: prdata_out = 32'h00000000;
    endcase
  end
endmodule

/* File: imsc_asserts.sv */
// Checker for the carrier between the controller end and the core end.
// Assumes one clock domain; watches the carrier's signals as plain inputs.
`timescale 1ns/1ps
module imsc_asserts (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic irq_pend,
  input wire logic [2:0] irq_level,
  input wire logic [1:0] irq_factor,
  input wire logic irq_accept
);
  // ==========================================================
  // Read answers decoded by the held request address
  wire rd_ack = reg_ack && !reg_we;
  wire stk_hit = reg_addr == imsc_pkg::MASK_LEVEL_STACK_ADDR;
  wire mode_hit = reg_addr == imsc_pkg::FACTOR_MODE_CTL_0_ADDR;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // ==========================================================
  // Handshake: one answer a cycle after taking, request held until then
  property p_ack_next; reg_req && !reg_ack |=> reg_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("answer not one cycle after request");
  property p_ack_drop; reg_ack |-> reg_req ##1 (!reg_req && !reg_ack); endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request not released after answer");
  property p_req_hold;
    reg_req && !reg_ack |=> $stable(reg_addr) && $stable(reg_we) && $stable(reg_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before answer");
  // ==========================================================
  // Read data layout: gap bits and the command bit never read back
  property p_stk_gaps; rd_ack && stk_hit |-> (reg_rdata & 32'h88888888) == 32'h0; endproperty
  a_stk_gaps: assert property (p_stk_gaps) else $error("stack gap bit read as one");
  property p_mode_gaps; rd_ack && mode_hit |-> (reg_rdata & 32'h88888888) == 32'h0; endproperty
  a_mode_gaps: assert property (p_mode_gaps) else $error("mode word gap bit read as one");
  property p_unmapped; rd_ack && !stk_hit && !mode_hit |-> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ==========================================================
  // Notification: a level follows a pending request, none otherwise
  property p_pend_lvl; irq_pend |=> irq_level != 3'h0; endproperty
  a_pend_lvl: assert property (p_pend_lvl) else $error("pending with level zero");
  property p_idle_lvl; !irq_pend |=> irq_level == 3'h0; endproperty
  a_idle_lvl: assert property (p_idle_lvl) else $error("level shown with nothing pending");
  property p_accept_pend; irq_accept |-> irq_pend; endproperty
  a_accept_pend: assert property (p_accept_pend) else $error("accept with nothing pending");
  c_accept: cover property (irq_accept);
  c_stk_read: cover property (rd_ack && stk_hit);
  c_stk_write: cover property (reg_ack && reg_we && stk_hit);
endmodule

/* File: imsc_tb.sv */
// Testbench joining the controller end and the core end over the carrier.
// Assumes a 50 MHz clock; the core end answers APB with no wait states.
`timescale 1ns/1ps
module imsc_tb;
  // ==========================================================
  // Stimulus, clock, carrier and stack model
  localparam logic [31:0] MODE_A = imsc_pkg::FACTOR_MODE_CTL_0_ADDR;
  localparam logic [31:0] STK_A = imsc_pkg::MASK_LEVEL_STACK_ADDR;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic sw_req_n = 1'b1;
  logic [2:0] req_pin = 3'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic irq_out;
  logic dma_trig;
  logic [2:0] dma_chan;
  logic [2:0] stk [8];
  int num_errors = 0;
  int total_checks = 0;
  imsc_link_if link_if ();
  always #10 mclk_in = ~mclk_in;
  imsc_ctl_dev imsc_ctl_dev_inst (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .link(link_if.dev),
    .sw_req_n_in(sw_req_n), .req_pin_in(req_pin), .dma_trig_out(dma_trig),
    .dma_chan_out(dma_chan));
  imsc_core_end imsc_core_end_inst (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .link(link_if.core), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .irq_out(irq_out));
  imsc_asserts imsc_asserts_inst (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .reg_req(link_if.reg_req), .reg_we(link_if.reg_we), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_rdata(link_if.reg_rdata), .reg_ack(link_if.reg_ack),
    .irq_pend(link_if.irq_pend), .irq_level(link_if.irq_level),
    .irq_factor(link_if.irq_factor), .irq_accept(link_if.irq_accept));
  // ==========================================================
  // Reporting
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail();
    num_errors++;
    end_sim();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ==========================================================
  // APB master: request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail();
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic st(input logic [7:0] e, input logic [7:0] m);
    logic [31:0] q;
    apb(1'b0, imsc_pkg::CORE_STATUS_OFS, 32'h0, q);
    check({24'h0, q[7:0] & m}, {24'h0, e});
  endtask
  // Device access through the core end; busy is polled, never assumed
  task automatic dv(input logic w, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    wr(imsc_pkg::CORE_ADDR_OFS, a);
    wr(imsc_pkg::CORE_WDATA_OFS, d);
    wr(imsc_pkg::CORE_CMD_OFS, {31'h0, w});
    n = 0;
    do begin
      apb(1'b0, imsc_pkg::CORE_STATUS_OFS, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (q[0] !== 1'b0) fail();
    apb(1'b0, imsc_pkg::CORE_RDATA_OFS, 32'h0, q);
  endtask
  task automatic dw(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    dv(1'b1, a, d, q);
  endtask
  task automatic dr(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    dv(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  // ==========================================================
  // Stack model and helpers
  function automatic logic [31:0] pack();
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < 8; k++) v[4 * k +: 3] = stk[k];
    return v;
  endfunction
  task automatic ovr(input logic [2:0] v);
    dw(STK_A, {1'b1, 28'h0, v});
    stk[0] = v;
  endtask
  // Accept, then compare taken level, taken factor and the pushed stack
  task automatic acc(input logic [2:0] l, input logic [1:0] f);
    wr(imsc_pkg::CORE_ACCEPT_OFS, 32'h1);
    for (int k = 7; k > 0; k--) stk[k] = stk[k - 1];
    stk[0] = l;
    st({f, l, 3'h0}, 8'hf8);
    dr(STK_A, pack());
  endtask
  // Pins pass two sync stages before they count; margin of two more edges
  task automatic pins(input logic [2:0] p, input logic s);
    req_pin <= p;
    sw_req_n <= s;
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic trig(input logic [2:0] ch);
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (dma_trig !== 1'b1 && n < 10);
    if (dma_trig !== 1'b1) fail();
    @(negedge mclk_in);
    check({29'h0, dma_chan}, {29'h0, ch});
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_reset();
    logic [31:0] q;
    dr(MODE_A, imsc_pkg::FACTOR_MODE_CTL_0_RST);
    dr(STK_A, imsc_pkg::MASK_LEVEL_STACK_RST);
    dr(32'hffffe004, 32'h0);
    apb(1'b0, 8'h20, 32'h0, q);
    check(q, 32'h0);
    st(8'h00, 8'hff);
  endtask
  task automatic s_fields();
    dw(MODE_A, 32'hffffffff);
    dr(MODE_A, 32'h77777777);
    dw(STK_A, 32'hffffffff);
    stk[0] = 3'h7;
    dr(STK_A, 32'h00000007);
    dw(MODE_A, 32'h0);
  endtask
  task automatic s_stack();
    logic [31:0] q;
    dw(MODE_A, 32'h27272600);
    pins(3'h7, 1'b1);
    ovr(3'h6);
    st(8'h04, 8'h04);
    acc(3'h7, 2'h2);
    st(8'h00, 8'h04);
    @(negedge mclk_in);
    check({31'h0, irq_out}, 32'h0);
    wr(imsc_pkg::CORE_IRQ_MASK_OFS, 32'h4);
    @(negedge mclk_in);
    check({31'h0, irq_out}, 32'h1);
    wr(imsc_pkg::CORE_IRQ_STAT_OFS, 32'h4);
    @(negedge mclk_in);
    check({31'h0, irq_out}, 32'h0);
    // Done and pending-seen stay sticky; only the accepted bit was cleared
    apb(1'b0, imsc_pkg::CORE_IRQ_STAT_OFS, 32'h0, q);
    check(q, 32'h3);
    apb(1'b0, imsc_pkg::CORE_IRQ_MASK_OFS, 32'h0, q);
    check(q, 32'h4);
    // Eight pushes overflow the seven saved slots; eight pops empty them
    for (int k = 0; k < 8; k++) begin
      ovr(3'(k % 7));
      acc(3'h7, 2'h2);
    end
    for (int k = 0; k < 8; k++) begin
      dw(STK_A, 32'h0);
      for (int j = 0; j < 7; j++) stk[j] = stk[j + 1];
      stk[7] = 3'h0;
      dr(STK_A, pack());
    end
  endtask
  task automatic s_modes();
    pins(3'h3, 1'b1);
    dw(MODE_A, 32'h65440203);
    ovr(3'h0);
    st(8'h00, 8'h04);
    pins(3'h7, 1'b1);
    acc(3'h5, 2'h3);
    st(8'h00, 8'h04);
    ovr(3'h0);
    pins(3'h5, 1'b1);
    acc(3'h4, 2'h2);
    ovr(3'h0);
    pins(3'h4, 1'b1);
    acc(3'h2, 2'h1);
    st(8'h00, 8'h04);
    ovr(3'h1);
    st(8'h04, 8'h04);
    pins(3'h5, 1'b0);
    acc(3'h3, 2'h0);
    ovr(3'h0);
    dw(MODE_A, 32'h00002023);
    st(8'h00, 8'h04);
  endtask
  task automatic s_dma();
    pins(3'h0, 1'b1);
    dw(MODE_A, 32'h32007500);
    req_pin <= 3'h1;
    trig(3'h5);
    st(8'h00, 8'h04);
    req_pin <= 3'h5;
    trig(3'h2);
    // Software source low level and a falling edge, both routed to transfers
    dw(MODE_A, 32'h00530017);
    pins(3'h7, 1'b1);
    sw_req_n <= 1'b0;
    trig(3'h7);
    req_pin <= 3'h5;
    trig(3'h3);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    foreach (stk[k]) stk[k] = 3'h0;
    repeat (10) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    s_reset();
    s_fields();
    s_stack();
    s_modes();
    s_dma();
    end_sim();
  end
endmodule
